// File: src/sdio_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module sdio_ahb_slave
   import sdio_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Register side
   sdio_reg_if.bus regs
);
   sdio_ahb_st_t st_r;
   sdio_ahb_st_t st_nxt;

   // ==========================================
   // Transfer sequencing
   // Reads take one wait state so hrdata leaves a flop
   always_comb begin
      st_nxt = st_r;
      st_nxt.wr_pend = 1'b0;
      st_nxt.resp = 1'b0;
      if (st_r.rd_pend) begin
         st_nxt.rdata = regs.rd_data;
         st_nxt.ready = 1'b1;
         st_nxt.rd_pend = 1'b0;
      end
      if (hsel && htrans[1] && hready) begin
         st_nxt.idx = haddr[31:2];
         if (hwrite) begin
            // Sub-word writes are dropped
            st_nxt.wr_pend = (hsize == HSIZE_WORD);
         end else begin
            st_nxt.rd_pend = 1'b1;
            st_nxt.ready = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '{wr_pend: 1'b0, rd_pend: 1'b0, idx: '0, ready: 1'b1, resp: 1'b0, rdata: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regs.wr_en = st_r.wr_pend;
   assign regs.wr_idx = st_r.idx;
   assign regs.wr_data = hwdata;
   assign regs.rd_idx = st_r.idx;
   assign hreadyout = st_r.ready;
   assign hrdata = st_r.rdata;
   assign hresp = st_r.resp;
endmodule // sdio_ahb_slave
`default_nettype wire

// File: src/sdio_pkg.sv
`default_nettype none
package sdio_pkg;
   // ==========================================
   // Register indices (byte address is index * 4)
   localparam logic [29:0] IDX_OUT1_SEL = 30'h0000_2210;
   localparam logic [29:0] IDX_OUT2_SEL = 30'h0000_2211;
   localparam logic [29:0] IDX_OUT3_SEL = 30'h0000_2212;
   localparam logic [29:0] IDX_OUT4_SEL = 30'h0000_2213;
   localparam logic [29:0] IDX_INPUTS = 30'h0000_60fd;
   localparam logic [29:0] IDX_OUT_COUNT = 30'h0000_60fe;
   localparam logic [29:0] IDX_PHYS_OUT = 30'h0000_6100;
   localparam logic [29:0] IDX_FORCE_MASK = 30'h0000_6101;

   // ==========================================
   // Field layout
   localparam int SEL_POL_BIT = 15;
   localparam int SEL_CODE_LSB = 0;
   localparam int IN_NEG_BIT = 0;
   localparam int IN_POS_BIT = 1;
   localparam int IN_ORG_BIT = 2;
   localparam int IN_DI_LSB = 16;
   localparam int IN_STO_BIT = 31;
   localparam int PHYS_FORCE_LSB = 16;
   localparam int PHYS_STAT_LSB = 24;
   localparam int MASK_LSB = 16;

   // ==========================================
   // Reset values and constants
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam logic [3:0] PHYS_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [7:0] OUT_ENTRY_COUNT = 8'h02;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ==========================================
   // Output function codes
   localparam logic [7:0] FN_NONE = 8'h00;
   localparam logic [7:0] FN_BRAKE = 8'h01;
   localparam logic [7:0] FN_READY = 8'h03;
   localparam logic [7:0] FN_IN_POSITION_SECOND = 8'h0b;
   localparam logic [7:0] FN_ORIGIN = 8'h10;
   localparam logic [7:0] FN_IOUT_LAST = 8'h17;
   localparam logic [4:0] FN_HIGH_BASE = 5'h0b;

   // ==========================================
   // State records
   typedef struct packed {
      logic [3:0][15:0] sel;
      logic [3:0] phys;
      logic [3:0] mask;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] filt;
      logic [3:0] pin;
   } sdio_st_t;

   typedef struct packed {
      logic wr_pend;
      logic rd_pend;
      logic [29:0] idx;
      logic ready;
      logic resp;
      logic [31:0] rdata;
   } sdio_ahb_st_t;
endpackage
`default_nettype wire

// File: src/sdio_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdio_reg_if;
   logic wr_en;
   logic [29:0] wr_idx;
   logic [31:0] wr_data;
   logic [29:0] rd_idx;
   logic [31:0] rd_data;
   modport bus (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
   modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// File: src/sdio_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdio_top
   import sdio_pkg::*;
#(
   parameter int NUM_OUT = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Drive status functions, same clock
   input wire logic brake_flag,
   input wire logic fault_flag,
   input wire logic servo_ready_flag,
   input wire logic zero_velocity_flag,
   input wire logic in_position_first,
   input wire logic torque_limited_flag,
   input wire logic velocity_limited_flag,
   input wire logic velocity_reached_flag,
   input wire logic warning_flag,
   input wire logic rotation_detected_flag,
   input wire logic in_position_second,
   input wire logic origin_found_flag,
   input wire logic end_of_motion_flag,
   input wire logic [5:0] indexed_general_output,
   // Connector inputs, asynchronous
   input wire logic negative_limit_switch,
   input wire logic positive_limit_switch,
   input wire logic origin_sensor,
   input wire logic [3:0] input_pin,
   input wire logic safe_torque_off_input,
   // Connector outputs
   output logic [NUM_OUT-1:0] output_pin
);
   sdio_st_t st_r;
   sdio_st_t st_nxt;
   sdio_reg_if reg_if ();
   logic [18:0] fn_vec;
   logic [7:0] raw_in;

   // ==========================================
   // Bus slave
   sdio_ahb_slave u_ahb (
      .sys_clk(sys_clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .regs(reg_if.bus)
   );

   // ==========================================
   // Helpers
   function automatic logic sel_hit(input logic [29:0] idx, input int unsigned n);
      return idx == 30'(IDX_OUT1_SEL + n);
   endfunction

   // Active level of a function before polarity; unknown codes idle
   function automatic logic fn_level(input logic [7:0] code, input logic [18:0] fv);
      logic r;
      r = 1'b0;
      if (code >= FN_BRAKE && code <= FN_IN_POSITION_SECOND) begin
         r = fv[5'(code - FN_BRAKE)];
      end else if (code >= FN_ORIGIN && code <= FN_IOUT_LAST) begin
         r = fv[5'(code - FN_ORIGIN) + FN_HIGH_BASE];
      end
      return r;
   endfunction

   assign fn_vec = {indexed_general_output, end_of_motion_flag, origin_found_flag, in_position_second,
      rotation_detected_flag, warning_flag, velocity_reached_flag, velocity_limited_flag,
      torque_limited_flag, in_position_first, zero_velocity_flag, servo_ready_flag, fault_flag, brake_flag};
   assign raw_in = {safe_torque_off_input, input_pin, origin_sensor, positive_limit_switch,
      negative_limit_switch};

   // ==========================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      // Three-stage sampling; a level counts once stages two and three agree
      st_nxt.s1 = raw_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int b = 0; b < 8; b++) begin
         if (st_r.s2[b] == st_r.s3[b]) begin
            st_nxt.filt[b] = st_r.s3[b];
         end
      end
      if (reg_if.wr_en) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (sel_hit(reg_if.wr_idx, i)) begin
               // Reserved bits 14..8 are not stored
               st_nxt.sel[i] = {reg_if.wr_data[SEL_POL_BIT], 7'h00, reg_if.wr_data[SEL_CODE_LSB +: 8]};
            end
         end
         if (reg_if.wr_idx == IDX_PHYS_OUT) begin
            st_nxt.phys = reg_if.wr_data[PHYS_FORCE_LSB +: 4];
         end
         if (reg_if.wr_idx == IDX_FORCE_MASK) begin
            st_nxt.mask = reg_if.wr_data[MASK_LSB +: 4];
         end
      end
      for (int i = 0; i < NUM_OUT; i++) begin
         if (st_r.mask[i]) begin
            st_nxt.pin[i] = st_r.phys[i];
         end else begin
            // Unassigned code gives level 0, so the pin rests at its inactive level
            st_nxt.pin[i] = fn_level(st_r.sel[i][SEL_CODE_LSB +: 8], fn_vec) ^ st_r.sel[i][SEL_POL_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '{sel: {NUM_OUT{SEL_RESET}}, phys: PHYS_RESET, mask: MASK_RESET, s1: '0, s2: '0, s3: '0,
            filt: '0, pin: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign output_pin = st_r.pin;

   // ==========================================
   // Register read
   always_comb begin
      reg_if.rd_data = 32'h0000_0000;
      for (int i = 0; i < NUM_OUT; i++) begin
         if (sel_hit(reg_if.rd_idx, i)) begin
            reg_if.rd_data = {16'h0000, st_r.sel[i]};
         end
      end
      if (reg_if.rd_idx == IDX_INPUTS) begin
         reg_if.rd_data[IN_NEG_BIT] = st_r.filt[0];
         reg_if.rd_data[IN_POS_BIT] = st_r.filt[1];
         reg_if.rd_data[IN_ORG_BIT] = st_r.filt[2];
         reg_if.rd_data[IN_DI_LSB +: 4] = st_r.filt[6:3];
         // Safe-torque-off pin is high while its circuit is closed
         reg_if.rd_data[IN_STO_BIT] = ~st_r.filt[7];
      end
      if (reg_if.rd_idx == IDX_OUT_COUNT) begin
         reg_if.rd_data = {24'h00_0000, OUT_ENTRY_COUNT};
      end
      if (reg_if.rd_idx == IDX_PHYS_OUT) begin
         reg_if.rd_data[PHYS_FORCE_LSB +: 4] = st_r.phys;
         reg_if.rd_data[PHYS_STAT_LSB +: 4] = st_r.pin;
      end
      if (reg_if.rd_idx == IDX_FORCE_MASK) begin
         reg_if.rd_data[MASK_LSB +: 4] = st_r.mask;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_brake_decode: assert property (
      (!st_r.mask[0] && st_r.sel[0] == 16'h0001) |=> (output_pin[0] == $past(brake_flag)))
      else $error("pin 1 does not follow brake function");

   a_contact_b_invert: assert property (
      (!st_r.mask[0] && st_r.sel[0] == 16'h8003) |=> (output_pin[0] == !$past(servo_ready_flag)))
      else $error("contact B pin not inverted");

   a_polarity_select: assert property (
      (!st_r.mask[3] && st_r.sel[3] == 16'h0004) |=> (output_pin[3] == $past(zero_velocity_flag)))
      else $error("contact A pin not active high");

   a_indexed_decode: assert property (
      (!st_r.mask[1] && st_r.sel[1][7:0] == 8'h17) |=>
      (output_pin[1] == ($past(indexed_general_output[5]) ^ $past(st_r.sel[1][15]))))
      else $error("indexed output 5 not decoded");

   a_unassigned_idle: assert property (
      (!st_r.mask[2] && st_r.sel[2][7:0] == 8'h00) |=> (output_pin[2] == $past(st_r.sel[2][15])))
      else $error("unassigned pin not at inactive level");

   a_forced_level: assert property (
      ##1 ((output_pin & $past(st_r.mask)) == ($past(st_r.phys) & $past(st_r.mask))))
      else $error("forced pin does not match physical output bit");

   a_mask_write: assert property (
      (reg_if.wr_en && reg_if.wr_idx == IDX_FORCE_MASK) |=> (st_r.mask == $past(reg_if.wr_data[19:16])))
      else $error("mask register did not take the write");

   a_sel_reserved: assert property (
      (reg_if.rd_idx == IDX_OUT2_SEL) |-> (reg_if.rd_data[31:16] == 16'h0000 && reg_if.rd_data[14:8] == 7'h00))
      else $error("reserved select bits read nonzero");

   a_di_filter: assert property (
      (input_pin[0] [*4]) |=> (st_r.filt[3] == 1'b1))
      else $error("input pin 1 not seen after stable level");

   a_limit_bits: assert property (
      (reg_if.rd_idx == IDX_INPUTS) |-> (reg_if.rd_data[2:0] == st_r.filt[2:0] && reg_if.rd_data[15:3] == 13'h0000))
      else $error("limit or origin bits misplaced");

   a_sto_open: assert property (
      (safe_torque_off_input == 1'b0) [*4] ##1 (reg_if.rd_idx == IDX_INPUTS) |-> reg_if.rd_data[31])
      else $error("torque-off open not reported");

   a_status_echo: assert property (
      (reg_if.rd_idx == IDX_PHYS_OUT) |-> (reg_if.rd_data[27:24] == output_pin))
      else $error("output status bits differ from pins");

   // ==========================================
   // Further decode and input checks
   // Each code is watched on the pin the decode sweep rotates it onto
   a_fault_decode: assert property (
      (!st_r.mask[2] && st_r.sel[2][7:0] == 8'h02) |=>
      (output_pin[2] == ($past(fault_flag) ^ $past(st_r.sel[2][15]))))
      else $error("pin 3 does not follow fault function");

   a_ready_decode: assert property (
      (!st_r.mask[3] && st_r.sel[3][7:0] == 8'h03) |=>
      (output_pin[3] == ($past(servo_ready_flag) ^ $past(st_r.sel[3][15]))))
      else $error("pin 4 does not follow ready function");

   a_last_status_decode: assert property (
      (!st_r.mask[3] && st_r.sel[3][7:0] == 8'h0b) |=>
      (output_pin[3] == ($past(in_position_second) ^ $past(st_r.sel[3][15]))))
      else $error("pin 4 does not follow second in-position function");

   a_origin_decode: assert property (
      (!st_r.mask[0] && st_r.sel[0][7:0] == 8'h10) |=>
      (output_pin[0] == ($past(origin_found_flag) ^ $past(st_r.sel[0][15]))))
      else $error("pin 1 does not follow origin-found function");

   a_motion_end_decode: assert property (
      (!st_r.mask[1] && st_r.sel[1][7:0] == 8'h11) |=>
      (output_pin[1] == ($past(end_of_motion_flag) ^ $past(st_r.sel[1][15]))))
      else $error("pin 2 does not follow end-of-motion function");

   a_undefined_idle: assert property (
      (!st_r.mask[0] && st_r.sel[0][7:0] == 8'h0c) |=> (output_pin[0] == $past(st_r.sel[0][15])))
      else $error("undefined code does not rest at inactive level");

   a_sel_write: assert property (
      (reg_if.wr_en && reg_if.wr_idx == IDX_OUT1_SEL) |=>
      (st_r.sel[0] == {$past(reg_if.wr_data[15]), 7'h00, $past(reg_if.wr_data[7:0])}))
      else $error("select word did not take the write");

   a_phys_write: assert property (
      (reg_if.wr_en && reg_if.wr_idx == IDX_PHYS_OUT) |=> (st_r.phys == $past(reg_if.wr_data[19:16])))
      else $error("physical output bits did not take the write");

   a_neg_limit: assert property (
      ((!negative_limit_switch) [*4]) |=> (st_r.filt[0] == 1'b0))
      else $error("negative limit release not seen");

   a_pos_limit: assert property (
      (positive_limit_switch [*4]) |=> (st_r.filt[1] == 1'b1))
      else $error("positive limit not seen after stable level");

   a_origin_sensor: assert property (
      (origin_sensor [*4]) |=> (st_r.filt[2] == 1'b1))
      else $error("origin sensor not seen after stable level");

   a_di_open: assert property (
      ((!input_pin[3]) [*4]) |=> (st_r.filt[6] == 1'b0))
      else $error("input pin 4 open not seen");

   a_sto_closed: assert property (
      (safe_torque_off_input == 1'b1) [*4] ##1 (reg_if.rd_idx == IDX_INPUTS) |-> !reg_if.rd_data[31])
      else $error("torque-off closed reported open");
endmodule // sdio_top
`default_nettype wire

// File: testbench/sdio_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdio_field_model (
   // Switch positions chosen by the bench: sto, inputs 4..1, origin, pos, neg
   input wire logic [7:0] contact_cmd,
   // Contacts wired into the connector
   output logic negative_limit_switch,
   output logic positive_limit_switch,
   output logic origin_sensor,
   output logic [3:0] input_pin,
   output logic safe_torque_off_input
);
   // ==========================================
   // Contacts
   // Mechanical switches move off the clock grid, so the drive must synchronise
   initial {safe_torque_off_input, input_pin, origin_sensor, positive_limit_switch, negative_limit_switch} = 8'h00;
   always @(contact_cmd) begin
      #1.3;
      {safe_torque_off_input, input_pin, origin_sensor, positive_limit_switch, negative_limit_switch} = contact_cmd;
   end
endmodule // sdio_field_model
`default_nettype wire

// File: testbench/sdio_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdio_top_tb
   import sdio_pkg::*;
();
   // ==========================================
   // Signals
   logic sys_clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = HSIZE_WORD;
   logic hreadyout, hresp;
   logic [18:0] fl = 19'h0;
   logic [7:0] contact_cmd = 8'h00;
   wire logic neg_sw, pos_sw, org_sw, sto_sw;
   wire logic [3:0] din;
   logic [3:0] output_pin;
   int err_count = 0, n_tests = 0;

   sdio_top #(.NUM_OUT(4)) uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .brake_flag(fl[0]), .fault_flag(fl[1]), .servo_ready_flag(fl[2]),
      .zero_velocity_flag(fl[3]), .in_position_first(fl[4]), .torque_limited_flag(fl[5]),
      .velocity_limited_flag(fl[6]), .velocity_reached_flag(fl[7]), .warning_flag(fl[8]),
      .rotation_detected_flag(fl[9]), .in_position_second(fl[10]), .origin_found_flag(fl[11]),
      .end_of_motion_flag(fl[12]), .indexed_general_output(fl[18:13]), .negative_limit_switch(neg_sw),
      .positive_limit_switch(pos_sw), .origin_sensor(org_sw), .input_pin(din),
      .safe_torque_off_input(sto_sw), .output_pin(output_pin));

   sdio_field_model field (.contact_cmd(contact_cmd), .negative_limit_switch(neg_sw),
      .positive_limit_switch(pos_sw), .origin_sensor(org_sw), .input_pin(din), .safe_torque_off_input(sto_sw));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // ==========================================
   // Shared tasks
   task automatic stop_test;
      if (err_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Ready is looked at just before the edge, which is the value the edge samples
   task automatic bus(input logic w, input logic [29:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      logic r;
      logic rs;
      rs = 1'b0;
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= w;
      do begin
         @(negedge sys_clk);
         r = hreadyout;
         @(posedge sys_clk);
      end while (r !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      // Response is captured with the data, away from the launching edge
      do begin
         @(negedge sys_clk);
         r = hreadyout;
         rd = hrdata;
         rs = hresp;
         @(posedge sys_clk);
      end while (r !== 1'b1);
      chk({31'h0, rs}, 32'h0);
   endtask

   task automatic wr(input logic [29:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask

   task automatic rdc(input logic [29:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      chk(x, exp);
   endtask

   task automatic settle;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   function automatic logic fexp(input logic [7:0] c, input logic [18:0] f);
      if (c >= 8'h01 && c <= 8'h0b) return f[c - 8'h01];
      if (c >= 8'h10 && c <= 8'h17) return f[c - 8'h05];
      return 1'b0;
   endfunction

   // ==========================================
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 4; i++) rdc(IDX_OUT1_SEL + 30'(i), {16'h0, SEL_RESET});
      rdc(IDX_OUT_COUNT, {24'h0, OUT_ENTRY_COUNT});
      wr(IDX_OUT_COUNT, 32'hffff_ffff);
      rdc(IDX_OUT_COUNT, {24'h0, OUT_ENTRY_COUNT});
      wr(30'h0000_1234, 32'hffff_ffff);
      rdc(30'h0000_1234, 32'h0);
      rdc(IDX_PHYS_OUT, 32'h0);
      rdc(IDX_FORCE_MASK, 32'h0);
      chk({28'h0, output_pin}, 32'h0);
   endtask

   // Codes 0x00 to 0x18 on a rotating pin, alternating polarity, flags then inverted
   task automatic t_decode;
      logic [7:0] c;
      logic pol;
      fl <= 19'h2d6b5;
      for (int i = 0; i <= 8'h18; i++) begin
         c = 8'(i);
         pol = c[0];
         wr(IDX_OUT1_SEL + 30'(i % 4), {16'hffff, pol, 7'h7f, c});
         rdc(IDX_OUT1_SEL + 30'(i % 4), {16'h0, pol, 7'h0, c});
         chk({31'h0, output_pin[i % 4]}, {31'h0, fexp(c, fl) ^ pol});
         fl <= ~fl;
         settle;
         chk({31'h0, output_pin[i % 4]}, {31'h0, fexp(c, fl) ^ pol});
      end
   endtask

   // Example assignments on all pins at once, then a flag pattern and its inverse
   task automatic t_example;
      logic [3:0][15:0] sets [2] = '{{16'h0004, 16'h0000, 16'h8017, 16'h0001},
         {16'h8004, 16'h8000, 16'h0017, 16'h8003}};
      wr(IDX_FORCE_MASK, 32'h0);
      foreach (sets[k]) begin
         for (int i = 0; i < 4; i++) wr(IDX_OUT1_SEL + 30'(i), {16'h0, sets[k][i]});
         fl <= 19'h2d6b5;
         repeat (2) begin
            settle;
            for (int i = 0; i < 4; i++) begin
               chk({31'h0, output_pin[i]}, {31'h0, fexp(sets[k][i][7:0], fl) ^ sets[k][i][15]});
            end
            @(posedge sys_clk);
            fl <= ~fl;
         end
      end
   endtask

   task automatic t_inputs;
      logic [7:0] pats [2] = '{8'h2d, 8'hd2};
      foreach (pats[k]) begin
         @(posedge sys_clk);
         contact_cmd <= pats[k];
         repeat (6) @(posedge sys_clk);
         rdc(IDX_INPUTS, {~pats[k][7], 11'h0, pats[k][6:3], 13'h0, pats[k][2:0]});
      end
      wr(IDX_INPUTS, 32'h0);
      rdc(IDX_INPUTS, {~pats[1][7], 11'h0, pats[1][6:3], 13'h0, pats[1][2:0]});
   endtask

   task automatic t_forced;
      fl <= 19'h00001;
      for (int i = 0; i < 4; i++) wr(IDX_OUT1_SEL + 30'(i), 32'h0);
      wr(IDX_FORCE_MASK, 32'hfff5_ffff);
      rdc(IDX_FORCE_MASK, 32'h0005_0000);
      wr(IDX_PHYS_OUT, 32'h0003_0000);
      settle;
      chk({28'h0, output_pin}, 32'h1);
      rdc(IDX_PHYS_OUT, 32'h0103_0000);
      wr(IDX_OUT2_SEL, {24'h0, FN_BRAKE});
      wr(IDX_PHYS_OUT, 32'hfffc_ffff);
      settle;
      chk({28'h0, output_pin}, 32'h6);
      rdc(IDX_PHYS_OUT, 32'h060c_0000);
      wr(IDX_FORCE_MASK, 32'h0);
      settle;
      chk({28'h0, output_pin}, 32'h2);
   endtask

   // ==========================================
   // Sequence and watchdog
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      t_decode;
      t_inputs;
      t_forced;
      t_example;
      stop_test;
   end

   // Whole run needs about four hundred cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      stop_test;
   end
endmodule // sdio_top_tb
`default_nettype wire
